// ==== dsr_pkg.sv ====
// Shared constants and types for the dual-channel serial readout block
`default_nettype none
package dsr_pkg;

	// ----------------------------------------
	// Word format and timing
	// ----------------------------------------
	localparam int unsigned RESULT_BITS     = 16;
	localparam int unsigned FIFO_DEPTH      = 8;
	localparam int unsigned CLK_PERIOD_PS   = 20000;
	// Output valid after strobe fall, in picoseconds
	localparam int unsigned SDO_VALID_PS    = 3000;
	localparam int unsigned SDO_RELEASE_PS  = 3000;
	localparam int unsigned ECHOED_SHIFT_CLOCK_VALID_PS = 2000;
	// Longest times round down, never below one cycle
	localparam int unsigned SDO_VALID_CYC   = (SDO_VALID_PS / CLK_PERIOD_PS) < 1 ? 1 :
		SDO_VALID_PS / CLK_PERIOD_PS;
	localparam int unsigned SDO_RELEASE_CYC = (SDO_RELEASE_PS / CLK_PERIOD_PS) < 1 ? 1 :
		SDO_RELEASE_PS / CLK_PERIOD_PS;
	localparam logic [15:0] RESET_WORD      = 16'h0000;

	// ----------------------------------------
	// I/O standard select and sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		DSR_IO_CMOS,
		DSR_IO_LVDS,
		DSR_IO_LVDS_LP
	} dsr_io_type;

	typedef enum logic [1:0] {
		DSR_IDLE,
		DSR_SHIFT,
		DSR_DONE
	} dsr_state_type;

endpackage
`default_nettype wire

// ==== dsr_word_if.sv ====
// Valid/ready word carrier between the readout modules
`timescale 1ns/1ns
`default_nettype none
interface dsr_word_if #(parameter int unsigned WIDTH = 32);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== dsr_fifo.sv ====
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dsr_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	dsr_word_if.dst   wr,
	dsr_word_if.src   rd
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q, wptr_d, rptr_q, rptr_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	// ----------------------------------------
	// Pointer and count update
	// ----------------------------------------
	always_comb begin
		push   = wr.valid && (cnt_q != (AW+1)'(DEPTH)) && clk_en;
		pop    = rd.ready && (cnt_q != '0) && clk_en;
		wptr_d = push ? ((wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1) : wptr_q;
		rptr_d = pop ? ((rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1) : rptr_q;
		cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q  <= cnt_d;
		end
	end

	// Storage has no reset so it can map to distributed RAM
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wptr_q] <= wr.data;
		end
	end

	assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
	assign rd.valid = (cnt_q != '0);
	assign rd.data  = mem_q[rptr_q];
endmodule // dsr_fifo
`default_nettype wire

// ==== dsr_readout.sv ====
// Dual-channel conversion start and serial readout, device side
//
// Contract
// - Strobe falling edge holds the sample and starts a conversion cycle.
// - Strobe is single-ended whatever standard; host drives it low-jitter.
// - Each shift falling edge advances both channels one bit, MSB first.
// - Valid data appears within 3 ns after strobe falls; the code drives it on the fourth core_clk edge after the fall.
// - Outputs release to high impedance within 3 ns after strobe rises; the code releases them on the fourth core_clk edge after the rise.
// - Echoed clock derived from shift clock, skew-matched to data.
// - Data changes after echoed-clock fall, valid within 2 ns.
// - CMOS mode drives positive pins only; negative pins unused.
// - LVDS mode drives data and echoed clock as differential pairs.
// - CMOS mode: negative echoed-clock pin held high disables echoed clock.
// - Zero input sits between all-zeros and all-ones codes.
// - Result words are two's complement.
// - Data shifted is the previous conversion result: one cycle latency.
// - Static mode input selects CMOS, LVDS or low-power LVDS.
`timescale 1ns/1ns
`default_nettype none
module dsr_readout
	import dsr_pkg::*;
#(
	parameter int unsigned BITS  = RESULT_BITS,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input  wire logic            core_clk,
	input  wire logic            sys_rst,
	input  wire logic            clk_en,
	input  wire logic            conv_start_n,
	input  wire logic            shift_clk,
	input  wire logic [1:0]      io_mode_pin,
	input  wire logic            echo_disable_pin,
	input  wire logic            result_valid,
	input  wire logic [BITS-1:0] first_channel_result,
	input  wire logic [BITS-1:0] second_channel_result,
	output logic                 result_ready,
	output logic                 sample_hold,
	output logic                 first_channel_serial_out_p,
	output logic                 first_channel_serial_out_n,
	output logic                 first_channel_serial_oe,
	output logic                 second_channel_serial_out_p,
	output logic                 second_channel_serial_out_n,
	output logic                 second_channel_serial_oe,
	output logic                 echoed_shift_clock_p,
	output logic                 echoed_shift_clock_n,
	output logic                 echoed_shift_clock_oe,
	output logic                 overrun
);
	localparam int unsigned CW = $clog2(BITS + 1);

	// ----------------------------------------
	// Pin synchronisers: three stages, change taken when stages two and three agree
	// ----------------------------------------
	logic [2:0] cnv_sync_q, cnv_sync_d;
	logic [2:0] sck_sync_q, sck_sync_d;
	logic [2:0] dis_sync_q, dis_sync_d;
	logic       cnv_lvl_q, cnv_lvl_d;
	logic       sck_lvl_q, sck_lvl_d;
	logic       dis_lvl_q, dis_lvl_d;
	logic       cnv_fall, cnv_rise, sck_fall, sck_rise;

	always_comb begin
		cnv_sync_d = {cnv_sync_q[1:0], conv_start_n};
		sck_sync_d = {sck_sync_q[1:0], shift_clk};
		dis_sync_d = {dis_sync_q[1:0], echo_disable_pin};
		cnv_lvl_d  = (cnv_sync_q[2] == cnv_sync_q[1]) ? cnv_sync_q[2] : cnv_lvl_q;
		sck_lvl_d  = (sck_sync_q[2] == sck_sync_q[1]) ? sck_sync_q[2] : sck_lvl_q;
		dis_lvl_d  = (dis_sync_q[2] == dis_sync_q[1]) ? dis_sync_q[2] : dis_lvl_q;
		cnv_fall   = cnv_lvl_q && !cnv_lvl_d;
		cnv_rise   = !cnv_lvl_q && cnv_lvl_d;
		sck_fall   = sck_lvl_q && !sck_lvl_d;
		sck_rise   = !sck_lvl_q && sck_lvl_d;
	end

	always_ff @(posedge core_clk) begin
		// Idle levels preloaded so reset release makes no false edge
		if (sys_rst) begin
			cnv_sync_q <= 3'h7;
			sck_sync_q <= 3'h0;
			dis_sync_q <= 3'h0;
			cnv_lvl_q  <= 1'b1;
			sck_lvl_q  <= 1'b0;
			dis_lvl_q  <= 1'b0;
		end else if (clk_en) begin
			cnv_sync_q <= cnv_sync_d;
			sck_sync_q <= sck_sync_d;
			dis_sync_q <= dis_sync_d;
			cnv_lvl_q  <= cnv_lvl_d;
			sck_lvl_q  <= sck_lvl_d;
			dis_lvl_q  <= dis_lvl_d;
		end
	end

	// ----------------------------------------
	// Mode strap, caught after reset release
	// ----------------------------------------
	dsr_io_type mode_q, mode_d;
	logic       mode_caught_q, mode_caught_d;

	// A strap that moves later is ignored until the next reset
	always_comb begin
		mode_d        = mode_q;
		mode_caught_d = 1'b1;
		if (!mode_caught_q) begin
			unique case (io_mode_pin)
				2'h0:    mode_d = DSR_IO_CMOS;
				2'h1:    mode_d = DSR_IO_LVDS;
				default: mode_d = DSR_IO_LVDS_LP;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_q        <= DSR_IO_CMOS;
			mode_caught_q <= 1'b0;
		end else if (clk_en) begin
			mode_q        <= mode_d;
			mode_caught_q <= mode_caught_d;
		end
	end

	// ----------------------------------------
	// Result FIFO between the converter core and the shifter
	// ----------------------------------------
	dsr_word_if #(.WIDTH(2 * BITS)) core_word ();
	dsr_word_if #(.WIDTH(2 * BITS)) shift_word ();

	assign core_word.valid = result_valid;
	// Two's complement words pass through unaltered; zero sits at the sign boundary
	assign core_word.data  = {first_channel_result, second_channel_result};

	dsr_fifo #(
		.WIDTH (2 * BITS),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.wr       (core_word),
		.rd       (shift_word)
	);

	// ----------------------------------------
	// Conversion and shift sequencer
	// ----------------------------------------
	dsr_state_type    state_q, state_d;
	logic [BITS-1:0]  sh1_q, sh1_d, sh2_q, sh2_d;
	logic [BITS-1:0]  last1_q, last1_d, last2_q, last2_d;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic             drive_q, drive_d;
	logic             hold_q, hold_d;
	logic             eclk_q, eclk_d;
	logic             ovr_q, ovr_d;
	logic             rdy_q, rdy_d;
	logic             pop;

	assign shift_word.ready = pop;

	always_comb begin
		state_d = state_q;
		sh1_d   = sh1_q;
		sh2_d   = sh2_q;
		last1_d = last1_q;
		last2_d = last2_q;
		cnt_d   = cnt_q;
		drive_d = drive_q;
		hold_d  = hold_q;
		eclk_d  = eclk_q;
		pop     = 1'b0;
		rdy_d   = core_word.ready;
		if (cnv_fall) begin
			// Sampler holds and both channels load the previous result together
			hold_d  = 1'b1;
			sh1_d   = last1_q;
			sh2_d   = last2_q;
			// One finished result is taken per conversion; bursts wait in the FIFO
			if (shift_word.valid) begin
				pop     = 1'b1;
				last1_d = shift_word.data[2*BITS-1:BITS];
				last2_d = shift_word.data[BITS-1:0];
			end
			cnt_d   = CW'(BITS);
			drive_d = 1'b1;
			eclk_d  = 1'b0;
			state_d = DSR_SHIFT;
		end else if (cnv_rise) begin
			hold_d  = 1'b0;
			drive_d = 1'b0;
			state_d = DSR_IDLE;
		end else if (state_q == DSR_SHIFT) begin
			if (sck_rise) begin
				eclk_d = 1'b1;
			end
			if (sck_fall) begin
				eclk_d = 1'b0;
				sh1_d  = {sh1_q[BITS-2:0], 1'b0};
				sh2_d  = {sh2_q[BITS-2:0], 1'b0};
				cnt_d  = cnt_q - 1'b1;
				if (cnt_q == CW'(1)) begin
					state_d = DSR_DONE;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= DSR_IDLE;
			sh1_q   <= RESET_WORD;
			sh2_q   <= RESET_WORD;
			last1_q <= RESET_WORD;
			last2_q <= RESET_WORD;
			cnt_q   <= '0;
			drive_q <= 1'b0;
			hold_q  <= 1'b0;
			eclk_q  <= 1'b0;
			rdy_q   <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			sh1_q   <= sh1_d;
			sh2_q   <= sh2_d;
			last1_q <= last1_d;
			last2_q <= last2_d;
			cnt_q   <= cnt_d;
			drive_q <= drive_d;
			hold_q  <= hold_d;
			eclk_q  <= eclk_d;
			rdy_q   <= rdy_d;
		end
	end

	// ----------------------------------------
	// Overrun flag: strobe fell again before the last frame finished
	// ----------------------------------------
	always_comb begin
		ovr_d = ovr_q;
		// Sticky until reset so a host that checks late still sees it
		if (cnv_fall && cnt_q != '0) begin
			ovr_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ovr_q <= 1'b0;
		end else if (clk_en) begin
			ovr_q <= ovr_d;
		end
	end

	// ----------------------------------------
	// Pin drivers, all registered
	// ----------------------------------------
	logic lvds, eclk_en;
	logic d1p_q, d1n_q, d2p_q, d2n_q, ckp_q, ckn_q, oe_q, ckoe_q;

	// In LVDS the negative pins mirror the positive ones even while released
	always_comb begin
		lvds    = (mode_q != DSR_IO_CMOS);
		// Disable strap only counts in CMOS; host then latches on its own clock
		eclk_en = lvds || !dis_lvl_q;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			d1p_q  <= 1'b0;
			d1n_q  <= 1'b0;
			d2p_q  <= 1'b0;
			d2n_q  <= 1'b0;
			ckp_q  <= 1'b0;
			ckn_q  <= 1'b0;
			oe_q   <= 1'b0;
			ckoe_q <= 1'b0;
		end else if (clk_en) begin
			d1p_q  <= sh1_d[BITS-1];
			d2p_q  <= sh2_d[BITS-1];
			d1n_q  <= lvds & ~sh1_d[BITS-1];
			d2n_q  <= lvds & ~sh2_d[BITS-1];
			ckp_q  <= eclk_d & eclk_en;
			ckn_q  <= lvds & ~eclk_d;
			oe_q   <= drive_d;
			ckoe_q <= drive_d & eclk_en;
		end
	end

	assign first_channel_serial_out_p  = d1p_q;
	assign first_channel_serial_out_n  = d1n_q;
	assign first_channel_serial_oe     = oe_q;
	assign second_channel_serial_out_p = d2p_q;
	assign second_channel_serial_out_n = d2n_q;
	assign second_channel_serial_oe    = oe_q;
	assign echoed_shift_clock_p        = ckp_q;
	assign echoed_shift_clock_n        = ckn_q;
	assign echoed_shift_clock_oe       = ckoe_q;
	assign sample_hold                 = hold_q;
	assign overrun                     = ovr_q;
	assign result_ready                = rdy_q;
endmodule // dsr_readout
`default_nettype wire

// ==== dsr_host_model.sv ====
// Host receiver model: strobe, shift clock and bit capture
`timescale 1ns/1ns
`default_nettype none
module dsr_host_model (
	input  wire logic core_clk,
	output var logic  conv_start_n,
	output var logic  shift_clk,
	input  wire logic first_channel_serial_out,
	input  wire logic second_channel_serial_out,
	input  wire logic echo
);
	// Shift clock rests low between frames
	initial begin
		conv_start_n = 1'b1;
		shift_clk    = 1'b0;
	end
	// ----------------------------------------
	// One frame of nsh shifts
	// ----------------------------------------
	task automatic frame(input int nsh, output logic [15:0] w1, output logic [15:0] w2,
		output int echoes);
		echoes = 0;
		@(negedge core_clk);
		conv_start_n = 1'b0;
		repeat (8) @(negedge core_clk);
		for (int i = 0; i < nsh; i++) begin
			w1 = {w1[14:0], first_channel_serial_out};
			w2 = {w2[14:0], second_channel_serial_out};
			shift_clk = 1'b1;
			repeat (5) @(negedge core_clk);
			echoes += int'(echo);
			shift_clk = 1'b0;
			repeat (6) @(negedge core_clk);
		end
		conv_start_n = 1'b1;
		repeat (8) @(negedge core_clk);
	endtask
endmodule // dsr_host_model
`default_nettype wire

// ==== dsr_readout_sva.sv ====
// Port-level assertions for the serial readout
`timescale 1ns/1ns
`default_nettype none
module dsr_readout_sva (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       conv_start_n,
	input wire logic       shift_clk,
	input wire logic [1:0] io_mode_pin,
	input wire logic       echo_disable_pin,
	input wire logic       sample_hold,
	input wire logic       first_channel_serial_out_p,
	input wire logic       first_channel_serial_out_n,
	input wire logic       first_channel_serial_oe,
	input wire logic       second_channel_serial_out_p,
	input wire logic       second_channel_serial_out_n,
	input wire logic       second_channel_serial_oe,
	input wire logic       echoed_shift_clock_p,
	input wire logic       echoed_shift_clock_n,
	input wire logic       echoed_shift_clock_oe,
	input wire logic       overrun
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	strobe_start_a: assert property ($fell(conv_start_n) |-> ##[1:5] first_channel_serial_oe)
		else $error("output enable late after strobe fall");
	bus_release_a: assert property (conv_start_n[*5]
		|-> !first_channel_serial_oe && !sample_hold)
		else $error("outputs not released");
	chan_pair_a: assert property (second_channel_serial_oe == first_channel_serial_oe
		&& sample_hold == first_channel_serial_oe)
		else $error("channels or hold out of step");
	cmos_neg_a: assert property (io_mode_pin == 2'h0 |-> !first_channel_serial_out_n)
		else $error("negative pin driven in single-ended mode");
	cmos_neg_rest_a: assert property (io_mode_pin == 2'h0
		|-> !second_channel_serial_out_n && !echoed_shift_clock_n)
		else $error("second or clock negative pin driven in single-ended mode");
	lvds_pair_a: assert property (io_mode_pin != 2'h0 && first_channel_serial_oe
		|-> first_channel_serial_out_n == !first_channel_serial_out_p)
		else $error("pair not complementary");
	lvds_pair2_a: assert property (io_mode_pin != 2'h0 && second_channel_serial_oe
		|-> second_channel_serial_out_n == !second_channel_serial_out_p)
		else $error("second pair not complementary");
	clk_pair_a: assert property (io_mode_pin != 2'h0 && echoed_shift_clock_oe
		|-> echoed_shift_clock_n == !echoed_shift_clock_p)
		else $error("clock pair not complementary");
	echo_off_a: assert property ((io_mode_pin == 2'h0 && echo_disable_pin)[*6]
		|-> !echoed_shift_clock_p && !echoed_shift_clock_oe)
		else $error("echoed clock not disabled");
	echo_follow_a: assert property ((shift_clk && !echo_disable_pin)[*5]
		##0 first_channel_serial_oe |-> echoed_shift_clock_p)
		else $error("echoed clock does not follow shift clock");
	data_hold_a: assert property (($stable(shift_clk) && !conv_start_n)[*6]
		|-> $stable(second_channel_serial_out_p))
		else $error("data moved without a shift edge");
	overrun_keep_a: assert property (overrun |=> overrun)
		else $error("overrun flag dropped");
	cover property ($rose(first_channel_serial_oe));
	cover property ($rose(overrun));
	cover property (io_mode_pin == 2'h1 && first_channel_serial_oe);
endmodule // dsr_readout_sva
bind dsr_readout dsr_readout_sva sva_u (
	.core_clk                    (core_clk),
	.sys_rst                     (sys_rst),
	.conv_start_n                (conv_start_n),
	.shift_clk                   (shift_clk),
	.io_mode_pin                 (io_mode_pin),
	.echo_disable_pin            (echo_disable_pin),
	.sample_hold                 (sample_hold),
	.first_channel_serial_out_p  (first_channel_serial_out_p),
	.first_channel_serial_out_n  (first_channel_serial_out_n),
	.first_channel_serial_oe     (first_channel_serial_oe),
	.second_channel_serial_out_p (second_channel_serial_out_p),
	.second_channel_serial_out_n (second_channel_serial_out_n),
	.second_channel_serial_oe    (second_channel_serial_oe),
	.echoed_shift_clock_p        (echoed_shift_clock_p),
	.echoed_shift_clock_n        (echoed_shift_clock_n),
	.echoed_shift_clock_oe       (echoed_shift_clock_oe),
	.overrun                     (overrun)
);
`default_nettype wire

// ==== dsr_readout_test.sv ====
// Self-checking bench for the dual-channel serial readout
`timescale 1ns/1ns
`default_nettype none
module dsr_readout_test
	import dsr_pkg::*;
;
	localparam logic [15:0] WORDS [8] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0000,
		16'h8001, 16'h7ffe, 16'h5a5a, 16'ha5a5};
	logic        core_clk = 1'b0;
	logic        sys_rst;
	logic [1:0]  io_mode_pin;
	logic        echo_off;
	logic        rvalid;
	logic [15:0] r1;
	logic [15:0] r2;
	logic        rready, hold, s1p, s1n, s1oe, s2p, s2n, s2oe, ckp, ckn, ckoe, ovr;
	logic        cnv_n;
	logic        clk_en;
	logic        sck;
	logic [15:0] w1;
	logic [15:0] w2;
	int          echoes;
	int          errors = 0;
	int          tests_run = 0;
	int          cycles = 0;

	always #10 core_clk = ~core_clk;

	dsr_readout dut_u (
		.core_clk, .sys_rst, .clk_en(clk_en), .conv_start_n(cnv_n), .shift_clk(sck),
		.io_mode_pin, .echo_disable_pin(echo_off), .result_valid(rvalid),
		.first_channel_result(r1), .second_channel_result(r2), .result_ready(rready),
		.sample_hold(hold), .first_channel_serial_out_p(s1p), .first_channel_serial_out_n(s1n),
		.first_channel_serial_oe(s1oe), .second_channel_serial_out_p(s2p),
		.second_channel_serial_out_n(s2n), .second_channel_serial_oe(s2oe),
		.echoed_shift_clock_p(ckp), .echoed_shift_clock_n(ckn), .echoed_shift_clock_oe(ckoe),
		.overrun(ovr)
	);
	// A released output reads as the inverse, so a capture outside the frame shows up
	dsr_host_model host_u (.core_clk, .conv_start_n(cnv_n), .shift_clk(sck),
		.first_channel_serial_out(s1oe ? s1p : !s1p), .second_channel_serial_out(s2oe ? s2p : !s2p), .echo(ckoe && ckp));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop();
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Strap is caught after release, so it changes only under reset
	task automatic do_reset(input logic [1:0] mode);
		@(negedge core_clk);
		sys_rst = 1'b1;
		io_mode_pin = mode;
		repeat (8) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge core_clk);
		check({hold, s1oe, s2oe, s1p, s2p, ckp, ckoe, ovr}, 32'h0);
	endtask

	task automatic push(input logic [15:0] a, input logic [15:0] b);
		for (int i = 0; i < 50 && rready !== 1'b1; i++) @(negedge core_clk);
		r1 = a;
		r2 = b;
		rvalid = 1'b1;
		@(negedge core_clk);
		rvalid = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_fill_drain();
		foreach (WORDS[i]) push(WORDS[i], ~WORDS[i]);
		check(rready, 1'b0);
		for (int k = 0; k < 9; k++) begin
			echo_off = (k > 6);
			host_u.frame(16, w1, w2, echoes);
			check({w1, w2}, k == 0 ? {RESET_WORD, RESET_WORD} : {WORDS[k-1], ~WORDS[k-1]});
			check(echoes, echo_off ? 0 : 16);
		end
		echo_off = 1'b0;
		check(rready, 1'b1);
	endtask

	task automatic test_overrun();
		host_u.frame(4, w1, w2, echoes);
		check(ovr, 1'b0);
		host_u.frame(16, w1, w2, echoes);
		check(ovr, 1'b1);
	endtask

	// Strap values 1 and 2 (LVDS, low-power LVDS): clears overrun, shifts a pair of words
	task automatic test_modes();
		for (int m = 1; m < 3; m++) begin
			do_reset(m[1:0]);
			push(16'h1234, 16'hfedc);
			host_u.frame(16, w1, w2, echoes);
			host_u.frame(16, w1, w2, echoes);
			check({w1, w2}, 32'h1234fedc);
			check(echoes, 16);
		end
	endtask

	// Frozen core refuses a word; the held result is shifted again
	task automatic test_freeze();
		clk_en = 1'b0;
		push(16'hdead, 16'hbeef);
		clk_en = 1'b1;
		check(rready, 1'b1);
		repeat (2) host_u.frame(16, w1, w2, echoes);
		check({w1, w2}, 32'h1234fedc);
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		io_mode_pin = 2'h0;
		echo_off = 1'b0;
		rvalid = 1'b0;
		r1 = 16'h0;
		r2 = 16'h0;
		do_reset(2'h0);
		test_fill_drain();
		test_overrun();
		test_modes();
		test_freeze();
		report_and_stop();
	end
endmodule // dsr_readout_test
`default_nettype wire
